// [rtl/sba_pkg.sv]
package sba_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W   = 32;
  localparam int TT_W     = 5;
  localparam int TSIZ_W   = 4;
  localparam int BADDR_W  = 5;
  localparam int IRQ_PINS = 7;
  localparam int IRQ_N    = 8;
  localparam int PADDR_W  = 8;
  localparam int WIN_W    = 8;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [PADDR_W-1:0] REG_CTRL  = 8'h00;
  localparam logic [PADDR_W-1:0] REG_BCR   = 8'h04;
  localparam logic [PADDR_W-1:0] REG_HOST_PORT_CONTROL_REGISTER  = 8'h08;
  localparam logic [PADDR_W-1:0] REG_ADDR  = 8'h0C;
  localparam logic [PADDR_W-1:0] REG_XFER  = 8'h10;
  localparam logic [PADDR_W-1:0] REG_STAT  = 8'h14;
  localparam logic [PADDR_W-1:0] REG_SNOOP = 8'h18;
  localparam logic [PADDR_W-1:0] REG_WIN   = 8'h1C;

  // ==========================================================================
  // field positions
  localparam int CTRL_IMM_BIT   = 0;
  localparam int CTRL_SHA_BIT   = 1;
  localparam int CTRL_SHB_BIT   = 2;
  localparam int BCR_INTERNAL_SPACE_PORT_SIZE_BIT   = 0;
  localparam int HOST_PORT_CONTROL_REGISTER_HEN_BIT   = 0;
  localparam int XFER_TSIZ_LSB  = 8;
  localparam int XFER_BURST_BIT = 16;
  localparam int XFER_GBL_BIT   = 17;
  localparam int XFER_GO_BIT    = 31;
  localparam int STAT_BUSY_BIT  = 3;
  localparam int STAT_ARBI_BIT  = 4;
  localparam int STAT_HPE_BIT   = 5;
  localparam int STAT_HIT_BIT   = 6;
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_INTERNAL_SPACE_PORT_SIZE_BIT  = 8;
  localparam int STAT_HPORT_BIT = 9;
  localparam int WIN_LSB        = 24;

  // external interrupt pin positions
  localparam int IRQP_1 = 0;
  localparam int IRQP_2 = 1;
  localparam int IRQP_3 = 2;
  localparam int IRQP_5 = 3;
  localparam int IRQP_7 = 4;
  localparam int IRQP_A = 5;
  localparam int IRQP_B = 6;

  // ==========================================================================
  // reset values and counts
  localparam logic             RST_SHARED_IRQ = 1'b1;
  localparam logic [WIN_W-1:0] RST_WIN        = 8'h00;
  localparam logic [1:0]       INIT_CYC       = 2'h3;

  // ==========================================================================
  // shared bus lines, also used as per-bit output enables
  typedef struct packed {
    logic              br_n;
    logic              bg_n;
    logic              abb_n;
    logic              ts_n;
    logic              address_acknowledge_n;
    logic              burst_indicator_n;
    logic              gbl_n;
    logic [TT_W-1:0]   tt;
    logic [TSIZ_W-1:0] tsiz;
    logic [ADDR_W-1:0] addr;
  } sba_bus_t;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_REQ   = 3'b001,
    D_TEN   = 3'b010,
    D_REL   = 3'b011,
    D_GRANT = 3'b100,
    D_EXT   = 3'b101
  } sba_dev_st_t;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_REQ  = 3'b001,
    E_TEN  = 3'b010,
    E_REL  = 3'b011,
    E_ARB  = 3'b100
  } sba_ext_st_t;

endpackage : sba_pkg

// [rtl/sba_if.sv]
interface sba_if;

  sba_pkg::sba_bus_t             dev_o;
  sba_pkg::sba_bus_t             dev_oe_n;
  sba_pkg::sba_bus_t             ext_o;
  sba_pkg::sba_bus_t             ext_oe_n;
  sba_pkg::sba_bus_t             bus;
  logic [sba_pkg::IRQ_PINS-1:0]  irq_pin_n;
  logic [sba_pkg::BADDR_W-1:0]   burst_addr;
  logic                          host_port_enable_strap;
  logic                          arb_internal_strap;

  // an undriven line floats high through the board pull-up
  assign bus = (dev_o | dev_oe_n) & (ext_o | ext_oe_n);

  modport dev (
    input  bus, irq_pin_n, host_port_enable_strap, arb_internal_strap,
    output dev_o, dev_oe_n, burst_addr
  );

  modport ext (
    input  bus, burst_addr,
    output ext_o, ext_oe_n, irq_pin_n, host_port_enable_strap, arb_internal_strap
  );

endinterface : sba_if

// [rtl/sba_dev.sv]
module sba_dev (
  input  logic                        core_clk,
  input  logic                        reset,
  sba_if.dev                          bus,
  input  logic                        psel,
  input  logic                        penable,
  input  logic                        pwrite,
  input  logic [sba_pkg::PADDR_W-1:0] paddr,
  input  logic [31:0]                 pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [sba_pkg::IRQ_N-1:0]   irq_to_core,
  output logic                        data_bus_is_32,
  output logic                        host_port_active
);

  // ==========================================================================
  // state
  typedef struct packed {
    sba_pkg::sba_bus_t                 sync1;
    sba_pkg::sba_bus_t                 sync2;
    sba_pkg::sba_bus_t                 bus_o;
    sba_pkg::sba_bus_t                 bus_oe_n;
    logic [sba_pkg::IRQ_PINS-1:0]      irq_s1;
    logic [sba_pkg::IRQ_PINS-1:0]      irq_s2;
    logic [1:0]                        strap_s1;
    logic [1:0]                        strap_s2;
    logic [1:0]                        init_cnt;
    logic                              arb_internal;
    logic                              hpe_strap;
    logic                              imm;
    logic                              sha_irq;
    logic                              shb_irq;
    logic                              internal_space_port_size;
    logic                              host_port_on_bit;
    logic                              hport;
    logic [sba_pkg::ADDR_W-1:0]        addr;
    logic [sba_pkg::TT_W-1:0]          tt;
    logic [sba_pkg::TSIZ_W-1:0]        tsiz;
    logic                              burst;
    logic                              global_snoop_flag;
    logic                              go;
    logic                              done;
    logic                              hit;
    logic                              address_acknowledge_pend;
    logic [sba_pkg::WIN_W-1:0]         win;
    logic [sba_pkg::ADDR_W-1:0]        snoop_addr;
    sba_pkg::sba_dev_st_t              st;
    logic [sba_pkg::BADDR_W-1:0]       baddr;
    logic [sba_pkg::IRQ_N-1:0]         irq_core;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
  } sba_dev_state_t;

  localparam sba_dev_state_t RST = '{
    sync1: '1, sync2: '1, bus_o: '1, bus_oe_n: '1, irq_s1: '1, irq_s2: '1,
    sha_irq: sba_pkg::RST_SHARED_IRQ, shb_irq: sba_pkg::RST_SHARED_IRQ,
    win: sba_pkg::RST_WIN, st: sba_pkg::D_IDLE, default: '0
  };

  sba_dev_state_t    q;
  sba_dev_state_t    d;
  sba_pkg::sba_bus_t s;
  logic              access;
  logic              commit;

  assign s      = q.sync2;
  assign access = psel & penable;
  assign commit = access & q.pready & pwrite & ~q.pslverr;

  // ==========================================================================
  // next state
  always_comb begin
    logic        start;
    logic        ext_ts;
    logic        mapped;
    logic [31:0] rdata;
    start  = 1'b0;
    ext_ts = 1'b0;
    mapped = 1'b1;
    rdata  = '0;
    d      = q;

    // every pin input passes two flops before use
    d.sync1    = bus.bus;
    d.sync2    = q.sync1;
    d.irq_s1   = bus.irq_pin_n;
    d.irq_s2   = q.irq_s1;
    d.strap_s1 = {bus.host_port_enable_strap, bus.arb_internal_strap};
    d.strap_s2 = q.strap_s1;

    // straps sampled just after reset release, then frozen
    if (q.init_cnt != sba_pkg::INIT_CYC) begin
      d.init_cnt     = q.init_cnt + 2'h1;
      d.arb_internal = q.strap_s2[0];
      d.hpe_strap    = q.strap_s2[1];
    end

    // ========================================================================
    // interrupt routing
    d.irq_core    = '0;
    d.irq_core[1] = ~q.irq_s2[sba_pkg::IRQP_1] | (q.sha_irq & ~q.irq_s2[sba_pkg::IRQP_A]);
    d.irq_core[2] = ~q.irq_s2[sba_pkg::IRQP_2];
    d.irq_core[3] = ~q.irq_s2[sba_pkg::IRQP_3];
    d.irq_core[5] = ~q.irq_s2[sba_pkg::IRQP_5];
    d.irq_core[7] = ~q.irq_s2[sba_pkg::IRQP_7] | (q.shb_irq & ~q.irq_s2[sba_pkg::IRQP_B]);

    // ========================================================================
    // apb read mux
    case (paddr)
      sba_pkg::REG_CTRL: begin
        rdata[sba_pkg::CTRL_IMM_BIT] = q.imm;
        rdata[sba_pkg::CTRL_SHA_BIT] = q.sha_irq;
        rdata[sba_pkg::CTRL_SHB_BIT] = q.shb_irq;
      end
      sba_pkg::REG_BCR:   rdata[sba_pkg::BCR_INTERNAL_SPACE_PORT_SIZE_BIT] = q.internal_space_port_size;
      sba_pkg::REG_HOST_PORT_CONTROL_REGISTER:  rdata[sba_pkg::HOST_PORT_CONTROL_REGISTER_HEN_BIT] = q.host_port_on_bit;
      sba_pkg::REG_ADDR:  rdata = q.addr;
      sba_pkg::REG_XFER: begin
        rdata[sba_pkg::TT_W-1:0]                                        = q.tt;
        rdata[sba_pkg::XFER_TSIZ_LSB +: sba_pkg::TSIZ_W]                = q.tsiz;
        rdata[sba_pkg::XFER_BURST_BIT]                                  = q.burst;
        rdata[sba_pkg::XFER_GBL_BIT]                                    = q.global_snoop_flag;
        rdata[sba_pkg::XFER_GO_BIT]                                     = q.go;
      end
      sba_pkg::REG_STAT: begin
        rdata[2:0]                     = q.st;
        rdata[sba_pkg::STAT_BUSY_BIT]  = q.go;
        rdata[sba_pkg::STAT_ARBI_BIT]  = q.arb_internal;
        rdata[sba_pkg::STAT_HPE_BIT]   = q.hpe_strap;
        rdata[sba_pkg::STAT_HIT_BIT]   = q.hit;
        rdata[sba_pkg::STAT_DONE_BIT]  = q.done;
        rdata[sba_pkg::STAT_INTERNAL_SPACE_PORT_SIZE_BIT]  = q.internal_space_port_size;
        rdata[sba_pkg::STAT_HPORT_BIT] = q.internal_space_port_size & q.host_port_on_bit;
      end
      sba_pkg::REG_SNOOP: rdata = q.snoop_addr;
      sba_pkg::REG_WIN:   rdata[sba_pkg::WIN_LSB +: sba_pkg::WIN_W] = q.win;
      default:            mapped = 1'b0;
    endcase

    // one wait state: ready rises in the second access cycle
    d.pready = access & ~q.pready;
    if (access && !q.pready) begin
      d.prdata  = rdata;
      d.pslverr = ~mapped;
    end

    // ========================================================================
    // register writes, before the fsm so hardware sets win
    if (commit) begin
      case (paddr)
        sba_pkg::REG_CTRL: begin
          d.imm     = pwdata[sba_pkg::CTRL_IMM_BIT];
          d.sha_irq = pwdata[sba_pkg::CTRL_SHA_BIT];
          d.shb_irq = pwdata[sba_pkg::CTRL_SHB_BIT];
        end
        sba_pkg::REG_BCR: begin
          d.internal_space_port_size = pwdata[sba_pkg::BCR_INTERNAL_SPACE_PORT_SIZE_BIT];
          // narrowing the bus again takes the host port away
          d.host_port_on_bit  = q.host_port_on_bit & pwdata[sba_pkg::BCR_INTERNAL_SPACE_PORT_SIZE_BIT];
        end
        // ignored unless the bus is already 32 bits
        sba_pkg::REG_HOST_PORT_CONTROL_REGISTER:  d.host_port_on_bit = pwdata[sba_pkg::HOST_PORT_CONTROL_REGISTER_HEN_BIT] & q.internal_space_port_size;
        sba_pkg::REG_ADDR:  if (!q.go) d.addr = pwdata;
        sba_pkg::REG_XFER: begin
          if (!q.go) begin
            d.tt    = pwdata[sba_pkg::TT_W-1:0];
            d.tsiz  = pwdata[sba_pkg::XFER_TSIZ_LSB +: sba_pkg::TSIZ_W];
            d.burst = pwdata[sba_pkg::XFER_BURST_BIT];
            d.global_snoop_flag   = pwdata[sba_pkg::XFER_GBL_BIT];
            d.go    = pwdata[sba_pkg::XFER_GO_BIT] & ~q.imm;
            d.done  = q.done & ~pwdata[sba_pkg::XFER_GO_BIT];
          end
        end
        sba_pkg::REG_STAT:  if (pwdata[sba_pkg::STAT_HIT_BIT]) d.hit = 1'b0;
        sba_pkg::REG_WIN:   d.win = pwdata[sba_pkg::WIN_LSB +: sba_pkg::WIN_W];
        default: ;
      endcase
    end

    // ========================================================================
    // answering tenures of an external master
    ext_ts = ~s.ts_n & (q.st == sba_pkg::D_IDLE || q.st == sba_pkg::D_GRANT || q.st == sba_pkg::D_EXT);
    if (ext_ts) begin
      d.snoop_addr = s.addr;
      if (s.addr[sba_pkg::WIN_LSB +: sba_pkg::WIN_W] == q.win) begin
        d.address_acknowledge_pend = 1'b1;
        d.hit       = 1'b1;
      end
    end
    if (q.address_acknowledge_pend) begin
      d.address_acknowledge_pend       = 1'b0;
      d.bus_o.address_acknowledge_n    = 1'b0;
      d.bus_oe_n.address_acknowledge_n = 1'b0;
    end else begin
      d.bus_o.address_acknowledge_n    = 1'b1;
      d.bus_oe_n.address_acknowledge_n = 1'b1;
    end

    // ========================================================================
    // arbitration and own address tenure
    case (q.st)
      sba_pkg::D_IDLE: begin
        // memory controller owns the address lines in internal mode
        d.bus_o.addr    = q.addr;
        d.bus_oe_n.addr = {sba_pkg::ADDR_W{~q.imm}};
        if (q.init_cnt == sba_pkg::INIT_CYC && !q.imm) begin
          if (q.arb_internal) begin
            if (q.go && s.abb_n) begin
              start = 1'b1;
            end else if (!s.br_n && s.abb_n) begin
              d.bus_o.bg_n    = 1'b0;
              d.bus_oe_n.bg_n = 1'b0;
              d.st            = sba_pkg::D_GRANT;
            end
          end else if (q.go) begin
            d.bus_o.br_n    = 1'b0;
            d.bus_oe_n.br_n = 1'b0;
            d.st            = sba_pkg::D_REQ;
          end
        end
      end
      sba_pkg::D_REQ: begin
        if (!s.bg_n && s.abb_n) begin
          start           = 1'b1;
          d.bus_o.br_n    = 1'b1;
          d.bus_oe_n.br_n = 1'b1;
        end
      end
      sba_pkg::D_TEN: begin
        d.bus_o.ts_n = 1'b1;
        if (!s.address_acknowledge_n) begin
          d.bus_o.abb_n = 1'b1;
          d.bus_oe_n    = '1;
          d.bus_oe_n.abb_n = 1'b0;
          d.go          = 1'b0;
          d.done        = 1'b1;
          d.st          = sba_pkg::D_REL;
        end
      end
      sba_pkg::D_REL: begin
        d.bus_oe_n.abb_n = 1'b1;
        d.st             = sba_pkg::D_IDLE;
      end
      sba_pkg::D_GRANT: begin
        if (!s.abb_n || s.br_n) begin
          d.bus_o.bg_n    = 1'b1;
          d.bus_oe_n.bg_n = 1'b1;
          d.st            = s.abb_n ? sba_pkg::D_IDLE : sba_pkg::D_EXT;
        end
      end
      sba_pkg::D_EXT: begin
        if (s.abb_n) d.st = sba_pkg::D_IDLE;
      end
      default: d.st = sba_pkg::D_IDLE;
    endcase

    if (start) begin
      d.bus_o.addr       = q.addr;
      d.bus_o.tt         = q.tt;
      d.bus_o.tsiz       = q.tsiz;
      d.bus_o.burst_indicator_n     = ~q.burst;
      d.bus_o.gbl_n      = ~q.global_snoop_flag;
      d.bus_o.ts_n       = 1'b0;
      d.bus_o.abb_n      = 1'b0;
      d.bus_oe_n.addr    = '0;
      d.bus_oe_n.tt      = '0;
      d.bus_oe_n.tsiz    = '0;
      d.bus_oe_n.burst_indicator_n  = 1'b0;
      d.bus_oe_n.gbl_n   = 1'b0;
      d.bus_oe_n.ts_n    = 1'b0;
      d.bus_oe_n.abb_n   = 1'b0;
      d.st               = sba_pkg::D_TEN;
    end

    // five burst address lines straight to memory; [2:0] are bits 29..31
    d.baddr = q.addr[sba_pkg::BADDR_W-1:0];
    d.hport = d.internal_space_port_size & d.host_port_on_bit;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign bus.dev_o      = q.bus_o;
  assign bus.dev_oe_n   = q.bus_oe_n;
  assign bus.burst_addr = q.baddr;
  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign irq_to_core    = q.irq_core;
  assign data_bus_is_32   = q.internal_space_port_size;
  assign host_port_active = q.hport;

endmodule : sba_dev

// [rtl/sba_ext.sv]
module sba_ext (
  input  logic                            core_clk,
  input  logic                            reset,
  sba_if.ext                              bus,
  input  logic                            req_go,
  input  logic [sba_pkg::ADDR_W-1:0]      req_addr,
  input  logic [sba_pkg::TT_W-1:0]        req_tt,
  input  logic [sba_pkg::TSIZ_W-1:0]      req_size,
  input  logic                            req_burst,
  input  logic                            req_global,
  input  logic [sba_pkg::IRQ_PINS-1:0]    irq_req,
  input  logic                            host_boot,
  input  logic                            dev_internal_arb,
  output logic                            req_busy,
  output logic                            req_done
);

  // ==========================================================================
  // state
  typedef struct packed {
    sba_pkg::sba_bus_t              sync1;
    sba_pkg::sba_bus_t              sync2;
    sba_pkg::sba_bus_t              bus_o;
    sba_pkg::sba_bus_t              bus_oe_n;
    sba_pkg::sba_ext_st_t           st;
    logic                           address_acknowledge_pend;
    logic                           granted;
    logic [sba_pkg::IRQ_PINS-1:0]   irq_n;
    logic [1:0]                     strap;
    logic [sba_pkg::ADDR_W-1:0]     addr;
    logic [sba_pkg::TT_W-1:0]       tt;
    logic [sba_pkg::TSIZ_W-1:0]     tsiz;
    logic                           burst;
    logic                           global_snoop_flag;
    logic                           busy;
    logic                           done;
  } sba_ext_state_t;

  localparam sba_ext_state_t RST = '{
    sync1: '1, sync2: '1, bus_o: '1, bus_oe_n: '1, irq_n: '1,
    st: sba_pkg::E_IDLE, default: '0
  };

  sba_ext_state_t    q;
  sba_ext_state_t    d;
  sba_pkg::sba_bus_t s;

  assign s = q.sync2;

  // ==========================================================================
  // next state
  always_comb begin
    logic start;
    start   = 1'b0;
    d       = q;
    d.sync1 = bus.bus;
    d.sync2 = q.sync1;
    d.done  = 1'b0;
    d.irq_n = ~irq_req;
    d.strap = {host_boot, dev_internal_arb};

    if (req_go && !q.busy) begin
      d.busy  = 1'b1;
      d.addr  = req_addr;
      d.tt    = req_tt;
      d.tsiz  = req_size;
      d.burst = req_burst;
      d.global_snoop_flag   = req_global;
    end

    // memory slave: acknowledge device tenures seen in E_IDLE or E_ARB
    if (!s.ts_n && (q.st == sba_pkg::E_IDLE || q.st == sba_pkg::E_ARB)) d.address_acknowledge_pend = 1'b1;
    d.bus_o.address_acknowledge_n    = ~q.address_acknowledge_pend;
    d.bus_oe_n.address_acknowledge_n = ~q.address_acknowledge_pend;
    if (q.address_acknowledge_pend) d.address_acknowledge_pend = 1'b0;

    case (q.st)
      sba_pkg::E_IDLE: begin
        if (!q.strap[0] && !s.br_n && s.abb_n) begin
          d.bus_o.bg_n    = 1'b0;
          d.bus_oe_n.bg_n = 1'b0;
          d.st            = sba_pkg::E_ARB;
        end else if (q.busy) begin
          if (q.strap[0]) begin
            d.bus_o.br_n    = 1'b0;
            d.bus_oe_n.br_n = 1'b0;
            d.st            = sba_pkg::E_REQ;
          end else if (s.br_n && s.abb_n) begin
            start = 1'b1;
          end
        end
      end
      sba_pkg::E_REQ: begin
        if (!s.bg_n && s.abb_n) begin
          start           = 1'b1;
          d.bus_o.br_n    = 1'b1;
          d.bus_oe_n.br_n = 1'b1;
        end
      end
      sba_pkg::E_TEN: begin
        d.bus_o.ts_n = 1'b1;
        if (!s.address_acknowledge_n) begin
          d.bus_o.abb_n    = 1'b1;
          d.bus_oe_n       = '1;
          d.bus_oe_n.abb_n = 1'b0;
          d.busy           = 1'b0;
          d.done           = 1'b1;
          d.st             = sba_pkg::E_REL;
        end
      end
      sba_pkg::E_REL: begin
        d.bus_oe_n.abb_n = 1'b1;
        d.st             = sba_pkg::E_IDLE;
      end
      sba_pkg::E_ARB: begin
        if (!s.abb_n && !q.granted) begin
          d.granted       = 1'b1;
          d.bus_o.bg_n    = 1'b1;
          d.bus_oe_n.bg_n = 1'b1;
        end else if (q.granted && s.abb_n) begin
          d.granted = 1'b0;
          d.st      = sba_pkg::E_IDLE;
        end
      end
      default: d.st = sba_pkg::E_IDLE;
    endcase

    if (start) begin
      d.bus_o.addr      = q.addr;
      d.bus_o.tt        = q.tt;
      d.bus_o.tsiz      = q.tsiz;
      d.bus_o.burst_indicator_n    = ~q.burst;
      d.bus_o.gbl_n     = ~q.global_snoop_flag;
      d.bus_o.ts_n      = 1'b0;
      d.bus_o.abb_n     = 1'b0;
      d.bus_oe_n.addr   = '0;
      d.bus_oe_n.tt     = '0;
      d.bus_oe_n.tsiz   = '0;
      d.bus_oe_n.burst_indicator_n = 1'b0;
      d.bus_oe_n.gbl_n  = 1'b0;
      d.bus_oe_n.ts_n   = 1'b0;
      d.bus_oe_n.abb_n  = 1'b0;
      d.st              = sba_pkg::E_TEN;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign bus.ext_o                  = q.bus_o;
  assign bus.ext_oe_n               = q.bus_oe_n;
  assign bus.irq_pin_n              = q.irq_n;
  assign bus.host_port_enable_strap = q.strap[1];
  assign bus.arb_internal_strap     = q.strap[0];
  assign req_busy                   = q.busy;
  assign req_done                   = q.done;

endmodule : sba_ext

// [dv/sba_checker.sv]
module sba_checker (
  input wire logic   core_clk,
  input wire logic   reset,
  input wire sba_pkg::sba_bus_t dev_o,
  input wire sba_pkg::sba_bus_t dev_oe_n,
  input wire sba_pkg::sba_bus_t ext_o,
  input wire sba_pkg::sba_bus_t ext_oe_n,
  input wire logic   arb_internal_strap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========
  // driven-low views of the lines; dah is abb_n driven high
  logic dts, dab, dah, xak, dak, xab;
  assign dts = !dev_oe_n.ts_n && !dev_o.ts_n;
  assign dab = !dev_oe_n.abb_n && !dev_o.abb_n;
  assign dah = !dev_oe_n.abb_n && dev_o.abb_n;
  assign xak = !ext_oe_n.address_acknowledge_n && !ext_o.address_acknowledge_n;
  assign dak = !dev_oe_n.address_acknowledge_n && !dev_o.address_acknowledge_n;
  assign xab = !ext_oe_n.abb_n && !ext_o.abb_n;
  a_start_busy: assert property (dts |-> dab) else $error("start without busy");
  a_start_pulse: assert property (dts |=> !dts) else $error("start too long");
  a_type_held: assert property (dab && $past(dab) |-> $stable(dev_o.tt) && !dev_oe_n.tt[0])
    else $error("type moved");
  a_size_held: assert property (dab ##1 dab |-> $stable(dev_o.tsiz)) else $error("size moved");
  a_ack_ends: assert property (xak && dab |-> ##[1:4] dah) else $error("tenure not ended");
  a_busy_release: assert property (dah |=> dev_oe_n.abb_n) else $error("busy not released");
  a_no_double_busy: assert property (!(dab && xab)) else $error("busy clash");
  a_grant_mode: assert property (!dev_oe_n.bg_n |-> arb_internal_strap) else $error("bad grant");
  a_request_mode: assert property (!dev_oe_n.br_n |-> !arb_internal_strap) else $error("bad req");
  a_ack_pulse: assert property (dak |=> !dak) else $error("ack too long");
  cover property (dts);
  cover property (dak);
  cover property (!dev_oe_n.bg_n);
endmodule : sba_checker

// [dv/system_bus_arbitration_signals_bench.sv]
module system_bus_arbitration_signals_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset = 1, ext_reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er, go = 0, burst = 0, global_snoop_flag = 0, boot = 0, iarb = 0, busy, done, b32, hpa;
  logic [7:0]  paddr = 0, irqc;
  logic [31:0] pwdata = 0, prdata, rd, a = 0, cap_a;
  logic [4:0]  tt = 0, cap_t;
  logic [3:0]  sz = 0, cap_s;
  logic [6:0]  irq = 0;
  logic        cap_b, cap_g;
  int          failures = 0, compares = 0, i, m;
  sba_if sba_link();
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (sba_link.bus.ts_n === 1'b0)
    {cap_a, cap_t, cap_s, cap_b, cap_g} <= {sba_link.bus.addr, sba_link.bus.tt, sba_link.bus.tsiz,
                                            sba_link.bus.burst_indicator_n, sba_link.bus.gbl_n};
  sba_dev sba_dev_inst (.core_clk(core_clk), .reset(reset), .bus(sba_link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_to_core(irqc), .data_bus_is_32(b32), .host_port_active(hpa));
  sba_ext sba_ext_inst (.core_clk(core_clk), .reset(ext_reset), .bus(sba_link), .req_go(go), .req_addr(a),
    .req_tt(tt), .req_size(sz), .req_burst(burst), .req_global(global_snoop_flag), .irq_req(irq), .host_boot(boot),
    .dev_internal_arb(iarb), .req_busy(busy), .req_done(done));
  sba_checker sba_checker_inst (.core_clk(core_clk), .reset(reset), .dev_o(sba_link.dev_o),
    .dev_oe_n(sba_link.dev_oe_n), .ext_o(sba_link.ext_o), .ext_oe_n(sba_link.ext_oe_n),
    .arb_internal_strap(sba_link.arb_internal_strap));
  // ==========
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    int k;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge core_clk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      summarize();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  function automatic logic [7:0] ei(logic [6:0] r, logic sh);
    ei = 8'h00;
    {ei[1], ei[2], ei[3], ei[5], ei[7]} = {r[0] | (sh & r[5]), r[1], r[2], r[3], r[4] | (sh & r[6])};
  endfunction : ei
  // ==========
  // ext leaves reset first so the straps settle before the device samples them
  initial begin
    void'($urandom(50));
    for (m = 0; m < 2; m++) begin
      {ext_reset, reset, iarb, boot} <= {3'b111, 1'($urandom)};
      iarb <= 1'(m);
      repeat (8) @(posedge core_clk);
      ext_reset <= 0;
      repeat (3) @(posedge core_clk);
      reset <= 0;
      repeat (4) @(posedge core_clk);
      apb(0, 8'h14, 0);
      chk("arb", rd[4], m);
      chk("strap", rd[5], boot);
      apb(1, 8'h08, 1);
      apb(0, 8'h08, 0);
      chk("hen", rd, 0);
      apb(1, 8'h04, 1);
      apb(1, 8'h08, 1);
      apb(0, 8'h14, 0);
      chk("hport", {rd[9:8], hpa, b32}, 4'hF);
      apb(0, 8'h20, 0);
      chk("unmapped", er, 1);
      {a, tt, sz, burst, global_snoop_flag} = {$urandom, 9'($urandom), 2'($urandom)};
      apb(1, 8'h0C, a);
      apb(1, 8'h10, {1'b1, 13'h0, global_snoop_flag, burst, 4'h0, sz, 3'h0, tt});
      for (i = 0; i < 40 && rd[7] !== 1'b1; i++) apb(0, 8'h14, 0);
      chk("done", rd[7], 1);
      if (i == 40) summarize();
      chk("addr", cap_a, a);
      chk("qual", {cap_t, cap_s, cap_b, cap_g}, {tt, sz, !burst, !global_snoop_flag});
      chk("baddr", sba_link.burst_addr, a[4:0]);
      a = $urandom;
      apb(1, 8'h1C, {a[31:24], 24'h0});
      go <= 1;
      @(posedge core_clk);
      go <= 0;
      for (i = 0; i < 80 && done !== 1'b1; i++) @(posedge core_clk);
      chk("xdone", done, 1);
      if (i == 80) summarize();
      apb(0, 8'h18, 0);
      chk("snoop", rd, a);
      irq <= 7'($urandom);
      repeat (8) @(posedge core_clk);
      chk("irq", irqc, ei(irq, 1));
      apb(1, 8'h00, 0);
      repeat (8) @(posedge core_clk);
      chk("irq_sel", irqc, ei(irq, 0));
      a = $urandom;
      apb(1, 8'h0C, a);
      apb(1, 8'h00, 1);
      repeat (4) @(posedge core_clk);
      chk("imm", sba_link.bus.addr, a);
    end
    summarize();
  end
endmodule : system_bus_arbitration_signals_bench
